// >>> design/csf_regs.svh
/*
  Register indices, field positions, reset values and timing constants
  for the carrier sense and AGC freeze control block.
  Assumes it is included by bare name from the design files.
*/
`ifndef CSF_REGS_SVH
`define CSF_REGS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define CSF_IDX_FILTER    6'h10
`define CSF_IDX_CS_FREEZE 6'h11
`define CSF_IDX_GAIN_LIM  6'h12
`define CSF_IDX_CONTROL   6'h20
`define CSF_IDX_STATUS    6'h21

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CSF_RST_FILTER    3'h0
`define CSF_RST_CS_FREEZE 8'h65
`define CSF_RST_GAIN_LIM  8'h75
`define CSF_RST_CONTROL   1'h0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSF_F_CS_SET_HI   7
`define CSF_F_CS_SET_LO   6
`define CSF_F_CS_CLR      5
`define CSF_F_WAIT_HI     4
`define CSF_F_WAIT_LO     2
`define CSF_F_EXTRA_HI    1
`define CSF_F_EXTRA_LO    0
`define CSF_F_GAIN_FLOOR  7
`define CSF_F_GAIN_CEIL   6
`define CSF_F_LOCK_SHOWS  0

// ----------------------------------------
// Gain steps and hold lengths
// ----------------------------------------
`define CSF_GAIN_MIN      2'h0
`define CSF_GAIN_MED      2'h1
`define CSF_GAIN_MAX      2'h2
`define CSF_WAIT_FOREVER  3'h7
`define CSF_WAIT_C0       6'h10
`define CSF_WAIT_C1       6'h14
`define CSF_WAIT_C2       6'h18
`define CSF_WAIT_C3       6'h1C
`define CSF_WAIT_C4       6'h20
`define CSF_WAIT_C5       6'h28
`define CSF_WAIT_C6       6'h30
`define CSF_EXTRA_BASE    8'h10

// ----------------------------------------
// Rates
// ----------------------------------------
`define CSF_PCLK_HZ       20000000
`define CSF_RATE_UNIT_HZ  100
`define CSF_FILT_BW_HZ    307200
`define CSF_FILT_CLK_HZ   (2 * `CSF_FILT_BW_HZ)
`define CSF_ADC_CLK_HZ    1228800

`endif

// >>> design/csf_pkg.sv
/*
  Types shared by the carrier sense and AGC freeze control block.
  Assumes csf_regs.svh is available for the matching constants.
*/
package csf_pkg;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_HOLD,
    PH_EXTRA
  } csf_phase_type;

  typedef struct packed {
    logic [23:0] acc;
    logic        tick;
  } csf_tick_state_type;

  typedef struct packed {
    logic [2:0]    cfg_filter;
    logic [7:0]    cfg_cs;
    logic [7:0]    cfg_gain;
    logic          cfg_lock_shows;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          lock_s1;
    logic          lock_s2;
    logic          lock_prev;
    logic [1:0]    above_cnt;
    logic          below_cnt;
    logic          carrier;
    csf_phase_type phase;
    logic [5:0]    hold_cnt;
    logic [7:0]    extra_cnt;
    logic          freeze;
    logic          lock_status;
    logic [1:0]    gain_floor;
    logic [1:0]    gain_ceiling;
  } csf_state_type;

endpackage

// >>> design/csf_rate_tick.sv
/*
  Fractional rate generator: one-cycle tick at STEP*UNIT/divisor Hz.
  Assumes pclk at PCLK_HZ and a divisor of 1 to 8 from the same domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "csf_regs.svh"

module csf_rate_tick #(
  parameter logic [23:0] STEP    = 24'd6144,
  parameter logic [23:0] MODULUS = 24'd200000
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Rate control
  input  wire logic [3:0] divisor,
  // Tick
  output logic            tick
);

  csf_pkg::csf_tick_state_type st;
  csf_pkg::csf_tick_state_type next_st;
  logic [23:0]                 limit;
  logic [23:0]                 sum;

  // ----------------------------------------
  // Accumulate and wrap
  // ----------------------------------------
  // Phase error stays under one pclk period, no drift over time
  always_comb begin
    limit        = MODULUS * {20'h0, divisor};
    sum          = st.acc + STEP;
    next_st      = st;
    next_st.tick = 1'b0;
    if (sum >= limit) begin
      next_st.acc  = sum - limit;
      next_st.tick = 1'b1;
    end else begin
      next_st.acc = sum;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule
`default_nettype wire

// >>> design/csf_top.sv
/*
  Carrier sense debounce, AGC/AFC/RSSI freeze timing and second front
  amplifier gain limits, with an APB3 register slave.
  Assumes sample strobes and trigger pulses come from pclk logic; the
  PLL lock level is asynchronous and is synchronised here.
*/
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "csf_regs.svh"

// How it works
// RQ1 - Carrier sense set after set-code plus one consecutive samples at or above threshold
// RQ2 - Carrier sense cleared after one or two consecutive samples below, per bit
// RQ3 - Frequency switch, lock regained or receive power-up starts the freeze hold
// RQ4 - Hold lasts 16, 20, 24, 28, 32, 40 or 48 filter clocks
// RQ5 - Wait code 7 keeps levels frozen with no timeout
// RQ6 - Filter clock runs at twice the channel filter bandwidth
// RQ7 - Extra freeze of 16, 32, 64 or 128 ADC clocks follows
// RQ8 - Floor bit picks minimum or medium lowest gain step
// RQ9 - Ceiling bit picks medium or maximum highest gain step
// RQ10 - Filter bandwidth is 307.2 kHz over the decimation divisor
// RQ11 - A sample on the opposite side restarts the running counter
module csf_top (
  // APB3 slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Signal strength estimator
  input  wire logic        sample_valid,
  input  wire logic        sample_above,
  // Freeze triggers
  input  wire logic        freq_switch,
  input  wire logic        rx_power_up,
  input  wire logic        pll_lock,
  // Receive chain controls
  output logic             carrier_sense,
  output logic             freeze_levels,
  output logic             lock_status,
  output logic [1:0]       front_gain_floor,
  output logic [1:0]       front_gain_ceiling
);

  csf_pkg::csf_state_type st;
  csf_pkg::csf_state_type next_st;
  logic                   filt_tick;
  logic                   adc_tick;
  logic [3:0]             divisor;
  logic                   trigger;
  logic [1:0]             cs_set;
  logic                   cs_clr;
  logic [2:0]             wait_code;
  logic [1:0]             extra_code;
  logic [5:0]             hold_len;
  logic [7:0]             extra_len;
  logic                   setup;
  logic                   commit;
  logic [5:0]             index;
  logic                   hit;
  logic [31:0]            rd_word;

  // ----------------------------------------
  // Rate generators
  // ----------------------------------------
  // RQ10 divisor from decimation field
  assign divisor = {1'b0, st.cfg_filter} + 4'h1;

  // RQ6 filter clock at twice bandwidth
  csf_rate_tick #(
    .STEP    (24'(`CSF_FILT_CLK_HZ / `CSF_RATE_UNIT_HZ)),
    .MODULUS (24'(`CSF_PCLK_HZ / `CSF_RATE_UNIT_HZ))
  ) u_filt_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .divisor (divisor),
    .tick    (filt_tick)
  );

  csf_rate_tick #(
    .STEP    (24'(`CSF_ADC_CLK_HZ / `CSF_RATE_UNIT_HZ)),
    .MODULUS (24'(`CSF_PCLK_HZ / `CSF_RATE_UNIT_HZ))
  ) u_adc_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .divisor (4'h1),
    .tick    (adc_tick)
  );

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  assign cs_set     = st.cfg_cs[`CSF_F_CS_SET_HI:`CSF_F_CS_SET_LO];
  assign cs_clr     = st.cfg_cs[`CSF_F_CS_CLR];
  assign wait_code  = st.cfg_cs[`CSF_F_WAIT_HI:`CSF_F_WAIT_LO];
  assign extra_code = st.cfg_cs[`CSF_F_EXTRA_HI:`CSF_F_EXTRA_LO];

  // RQ4 hold length table
  always_comb begin
    unique case (wait_code)
      3'h0:    hold_len = `CSF_WAIT_C0;
      3'h1:    hold_len = `CSF_WAIT_C1;
      3'h2:    hold_len = `CSF_WAIT_C2;
      3'h3:    hold_len = `CSF_WAIT_C3;
      3'h4:    hold_len = `CSF_WAIT_C4;
      3'h5:    hold_len = `CSF_WAIT_C5;
      default: hold_len = `CSF_WAIT_C6;
    endcase
  end

  // RQ7 extra freeze doubles per code
  assign extra_len = `CSF_EXTRA_BASE << extra_code;

  // RQ3 any of the three events
  assign trigger = freq_switch | rx_power_up | (st.lock_s2 & ~st.lock_prev);

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign setup  = psel & ~penable;
  assign commit = psel & penable & st.pready & pwrite & ~st.pslverr;
  assign index  = paddr[7:2];

  always_comb begin
    hit     = (paddr[1:0] == 2'h0);
    rd_word = 32'h0;
    unique case (index)
      `CSF_IDX_FILTER:    rd_word = {29'h0, st.cfg_filter};
      `CSF_IDX_CS_FREEZE: rd_word = {24'h0, st.cfg_cs};
      `CSF_IDX_GAIN_LIM:  rd_word = {24'h0, st.cfg_gain};
      `CSF_IDX_CONTROL:   rd_word = {31'h0, st.cfg_lock_shows};
      `CSF_IDX_STATUS:    rd_word = {26'h0, st.phase, st.freeze, st.carrier,
                                     st.lock_s2, st.lock_status};
      default:            hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st         = st;
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;

    // No wait state: answer in the first access cycle
    if (setup) begin
      next_st.pready  = 1'b1;
      next_st.pslverr = ~hit;
      next_st.prdata  = pwrite ? 32'h0 : (hit ? rd_word : 32'h0);
    end
    if (commit) begin
      unique case (index)
        `CSF_IDX_FILTER:    next_st.cfg_filter     = pwdata[2:0];
        `CSF_IDX_CS_FREEZE: next_st.cfg_cs         = pwdata[7:0];
        `CSF_IDX_GAIN_LIM:  next_st.cfg_gain       = pwdata[7:0];
        `CSF_IDX_CONTROL:   next_st.cfg_lock_shows = pwdata[`CSF_F_LOCK_SHOWS];
        default:            next_st.cfg_lock_shows = st.cfg_lock_shows;
      endcase
    end

    // Lock pin passes two flops before use
    next_st.lock_s1   = pll_lock;
    next_st.lock_s2   = st.lock_s1;
    next_st.lock_prev = st.lock_s2;

    if (sample_valid) begin
      if (sample_above) begin
        // RQ11 opposite run restarts
        next_st.below_cnt = 1'b0;
        // RQ1 set after set-code plus one
        if (st.above_cnt >= cs_set) begin
          next_st.carrier = 1'b1;
        end else begin
          next_st.above_cnt = st.above_cnt + 2'h1;
        end
      end else begin
        // RQ11 opposite run restarts
        next_st.above_cnt = 2'h0;
        // RQ2 clear after one or two
        if (st.below_cnt >= cs_clr) begin
          next_st.carrier = 1'b0;
        end else begin
          next_st.below_cnt = 1'b1;
        end
      end
    end

    // RQ3 trigger restarts the hold
    if (wait_code == `CSF_WAIT_FOREVER) begin
      // RQ5 frozen with no timeout
      next_st.phase  = csf_pkg::PH_IDLE;
      next_st.freeze = 1'b1;
    end else if (trigger) begin
      next_st.phase    = csf_pkg::PH_HOLD;
      next_st.hold_cnt = 6'h0;
      next_st.freeze   = 1'b1;
    end else begin
      unique case (st.phase)
        csf_pkg::PH_IDLE: begin
          next_st.freeze = 1'b0;
        end
        csf_pkg::PH_HOLD: begin
          // RQ4 count filter clocks
          if (filt_tick) begin
            if (st.hold_cnt >= hold_len - 6'h1) begin
              next_st.phase     = csf_pkg::PH_EXTRA;
              next_st.extra_cnt = 8'h0;
            end else begin
              next_st.hold_cnt = st.hold_cnt + 6'h1;
            end
          end
        end
        csf_pkg::PH_EXTRA: begin
          // RQ7 count ADC clocks
          if (adc_tick) begin
            if (st.extra_cnt >= extra_len - 8'h1) begin
              next_st.phase  = csf_pkg::PH_IDLE;
              next_st.freeze = 1'b0;
            end else begin
              next_st.extra_cnt = st.extra_cnt + 8'h1;
            end
          end
        end
        default: begin
          next_st.phase = csf_pkg::PH_IDLE;
        end
      endcase
    end

    // RQ1 carrier shown on lock output
    next_st.lock_status = st.cfg_lock_shows ? next_st.carrier : st.lock_s2;

    // RQ8 lowest step
    next_st.gain_floor = st.cfg_gain[`CSF_F_GAIN_FLOOR] ? `CSF_GAIN_MED : `CSF_GAIN_MIN;
    // RQ9 highest step
    next_st.gain_ceiling = st.cfg_gain[`CSF_F_GAIN_CEIL] ? `CSF_GAIN_MAX : `CSF_GAIN_MED;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st                <= '0;
      st.cfg_filter     <= `CSF_RST_FILTER;
      st.cfg_cs         <= `CSF_RST_CS_FREEZE;
      st.cfg_gain       <= `CSF_RST_GAIN_LIM;
      st.cfg_lock_shows <= `CSF_RST_CONTROL;
      st.phase          <= csf_pkg::PH_IDLE;
      st.gain_floor     <= `CSF_GAIN_MIN;
      st.gain_ceiling   <= `CSF_GAIN_MAX;
    end else begin
      st <= next_st;
    end
  end

  assign prdata             = st.prdata;
  assign pready             = st.pready;
  assign pslverr            = st.pslverr;
  assign carrier_sense      = st.carrier;
  assign freeze_levels      = st.freeze;
  assign lock_status        = st.lock_status;
  assign front_gain_floor   = st.gain_floor;
  assign front_gain_ceiling = st.gain_ceiling;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_above;
    sample_valid && sample_above;
  endsequence

  sequence s_below;
    sample_valid && !sample_above;
  endsequence

  sequence s_hold_end;
    st.phase == csf_pkg::PH_HOLD && filt_tick && !trigger
      && wait_code != 3'h7 && st.hold_cnt == hold_len - 6'h1;
  endsequence

  // RQ1 set run completes
  a_cs_set_run: assert property ( // RQ1
    s_above ##0 (st.above_cnt >= cs_set) |=> carrier_sense)
    else $error("carrier sense not set after full run");

  // RQ11 rise only from an above sample
  a_cs_rise_cause: assert property ( // RQ11
    $rose(carrier_sense) |-> $past(sample_valid && sample_above
      && st.above_cnt >= cs_set))
    else $error("carrier sense rose without a full run");

  // RQ2 clear run completes
  a_cs_clear_run: assert property ( // RQ2
    s_below ##0 (st.below_cnt == cs_clr) |=> !carrier_sense)
    else $error("carrier sense not cleared after run below");

  // RQ2 fall only from a below sample
  a_cs_fall_cause: assert property ( // RQ2
    $fell(carrier_sense) |-> $past(sample_valid && !sample_above))
    else $error("carrier sense fell without a sample below");

  // RQ3 trigger freezes next cycle
  a_hold_start: assert property ( // RQ3
    trigger && wait_code != 3'h7 |=> freeze_levels
      && st.phase == csf_pkg::PH_HOLD && st.hold_cnt == 6'h0)
    else $error("trigger did not start the hold");

  // RQ4 hold ends into extra freeze
  a_hold_length: assert property ( // RQ4
    s_hold_end |=> st.phase == csf_pkg::PH_EXTRA && freeze_levels)
    else $error("hold did not end at its length");

  // RQ5 code 7 stays frozen
  a_wait_forever: assert property ( // RQ5
    wait_code == 3'h7 ##1 wait_code == 3'h7 |-> freeze_levels)
    else $error("levels released under wait code 7");

  // RQ7 extra freeze ends at its length
  a_extra_length: assert property ( // RQ7
    st.phase == csf_pkg::PH_EXTRA && adc_tick && !trigger && wait_code != 3'h7
      && st.extra_cnt == extra_len - 8'h1 |=> !freeze_levels)
    else $error("extra freeze did not end at its length");

  // RQ8 floor follows bit
  a_gain_floor: assert property ( // RQ8
    ##1 front_gain_floor == ($past(st.cfg_gain[7]) ? 2'h1 : 2'h0))
    else $error("gain floor does not follow its bit");

  // RQ9 ceiling follows bit
  a_gain_ceiling: assert property ( // RQ9
    ##1 front_gain_ceiling == ($past(st.cfg_gain[6]) ? 2'h2 : 2'h1))
    else $error("gain ceiling does not follow its bit");

  a_apb_answer: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");

endmodule
`default_nettype wire

// >>> dv/csf_est_model.sv
/*
  Signal strength estimator model: hands out one threshold decision per
  request, at once or after a short stall.
  Assumes requests arrive just after a rising pclk edge.
*/
`timescale 1ns/10ps
`default_nettype none

module csf_est_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Request from bench
  input  wire logic req,
  input  wire logic req_above,
  input  wire logic slow,
  // Estimator outputs
  output logic      sample_valid,
  output logic      sample_above
);
  logic [1:0] wait_cnt;
  logic       pend;
  logic       val;
  logic       last;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_valid <= 1'h0;
      sample_above <= 1'h0;
      pend         <= 1'h0;
      wait_cnt     <= 2'h0;
      val          <= 1'h0;
      last         <= 1'h0;
    end else begin
      sample_valid <= 1'h0;
      // Stale level inverted so nothing can ride on it
      sample_above <= ~last;
      if (req) begin
        pend     <= 1'h1;
        val      <= req_above;
        wait_cnt <= slow ? 2'h3 : 2'h0;
      end else if (pend && wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end else if (pend) begin
        pend         <= 1'h0;
        sample_valid <= 1'h1;
        sample_above <= val;
        last         <= val;
      end
    end
  end
endmodule

`default_nettype wire

// >>> dv/tb.sv
/*
  Self-checking bench for the carrier sense and freeze control block.
  Assumes the estimator model drives the samples and APB is wait-free.
*/
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, (g), (e)); end end

module tb;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, sample_valid, sample_above;
  logic        freq_switch, rx_power_up, pll_lock, req, req_above, slow;
  logic        carrier_sense, freeze_levels, lock_status;
  logic [1:0]  front_gain_floor, front_gain_ceiling;
  logic [31:0] rnd, r;
  logic        e, cs;
  int          n_mismatch, checks_done, cyc, up, dn, setc, clr;
  int          wt[7] = '{16, 20, 24, 28, 32, 40, 48};

  csf_top u_csf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_valid(sample_valid), .sample_above(sample_above),
    .freq_switch(freq_switch), .rx_power_up(rx_power_up), .pll_lock(pll_lock),
    .carrier_sense(carrier_sense), .freeze_levels(freeze_levels),
    .lock_status(lock_status), .front_gain_floor(front_gain_floor),
    .front_gain_ceiling(front_gain_ceiling));

  csf_est_model u_csf_est_model (.pclk(pclk), .presetn(presetn), .req(req),
    .req_above(req_above), .slow(slow), .sample_valid(sample_valid),
    .sample_above(sample_above));

  // ----------------------------------------
  // Clock, timeout, helpers
  // ----------------------------------------
  initial begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      results();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return (s >> 1) ^ (s[0] ? 32'hA3000000 : 32'h0);
  endfunction

  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // APB master: hold request until pready at a rising edge
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    // Answer and data taken at the rising edge that sees pready
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) n_mismatch++;
  endtask

  // ----------------------------------------
  // One sample through the estimator, with reference debounce
  // ----------------------------------------
  task automatic smp(input logic a);
    logic v;
    int   n;
    @(posedge pclk);
    req <= 1'h1; req_above <= a; slow <= rnd[3]; rnd = lfsr(rnd);
    @(posedge pclk);
    req <= 1'h0;
    v = 1'h0; n = 0;
    while (!v && n < 20) begin
      @(negedge pclk); v = (sample_valid === 1'h1); @(posedge pclk); n++;
    end
    if (a) begin up++; dn = 0; end else begin dn++; up = 0; end
    if (up >= setc + 1) cs = 1'h1;
    if (dn >= (clr ? 2 : 1)) cs = 1'h0;
    @(negedge pclk);
    `CHK(carrier_sense, cs)
    @(negedge pclk);
    `CHK(lock_status, cs)
  endtask

  // ----------------------------------------
  // Freeze length: between whole-tick bounds, ticks phase unknown
  // ----------------------------------------
  task automatic frz(input int k, input int w, input int x, input int dv);
    real tf, ta, lo, hi;
    int  n;
    tf = 20.0e6 * dv / 614400.0;
    ta = 20.0e6 / 1228800.0;
    lo = (wt[w] - 1) * tf + ((16 << x) - 1) * ta - 2.0;
    hi = wt[w] * tf + (16 << x) * ta + 6.0;
    @(posedge pclk);
    case (k)
      0: freq_switch <= 1'h1;
      1: rx_power_up <= 1'h1;
      default: pll_lock <= 1'h1;
    endcase
    @(posedge pclk);
    freq_switch <= 1'h0; rx_power_up <= 1'h0;
    if (k == 2) repeat (3) @(posedge pclk);
    @(negedge pclk);
    `CHK(freeze_levels, 1'h1)
    n = 0;
    while (freeze_levels === 1'h1 && n < 5000) begin @(negedge pclk); n++; end
    `CHK(n >= lo && n <= hi, 1'h1)
    @(posedge pclk);
    pll_lock <= 1'h0;
    repeat (4) @(posedge pclk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0]  ra[4] = '{8'h40, 8'h44, 8'h48, 8'h80};
    logic [31:0] rv[4] = '{32'h0, 32'h65, 32'h75, 32'h0};
    presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 8'h0;
    pwdata = 32'h0; freq_switch = 1'h0; rx_power_up = 1'h0; pll_lock = 1'h0;
    req = 1'h0; req_above = 1'h0; slow = 1'h0; rnd = 32'hB6F1; cs = 1'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      apb(1'h0, ra[i], 32'h0);
      `CHK(r, rv[i])
    end
    apb(1'h0, 8'h4C, 32'h0);
    `CHK({e, r}, 33'h100000000)
    apb(1'h1, 8'h46, 32'hFF);
    `CHK(e, 1'h1)
    // Limits: floor bit picks min/medium, ceiling bit medium/max
    for (int g = 0; g < 4; g++) begin
      apb(1'h1, 8'h48, {24'h0, g[1:0], 6'h35});
      repeat (2) @(posedge pclk);
      `CHK(front_gain_floor, (g[1] ? 2'h1 : 2'h0))
      `CHK(front_gain_ceiling, (g[0] ? 2'h2 : 2'h1))
      apb(1'h0, 8'h48, 32'h0);
      `CHK(r, {24'h0, g[1:0], 6'h35})
    end
    // Debounce over every set code and both clear settings
    apb(1'h1, 8'h80, 32'h1);
    for (int c = 0; c < 8; c++) begin
      setc = c >> 1; clr = c & 1;
      apb(1'h1, 8'h44, {24'h0, setc[1:0], clr[0], 5'h05});
      // Runs carry across config writes, as the counters do
      for (int s = 0; s < 16; s++) begin
        smp(s < 3 ? 1'h1 : (rnd[0] | rnd[1]));
        rnd = lfsr(rnd);
      end
      repeat (2) smp(1'h0);
      smp(1'h1);
    end
    // Hold and extra lengths across codes and triggers
    apb(1'h1, 8'h40, 32'h0);
    for (int w = 0; w < 7; w++) begin
      apb(1'h1, 8'h44, {24'h0, 3'h5, w[2:0], w[1:0]});
      frz(w % 3, w, w % 4, 1);
    end
    apb(1'h1, 8'h40, 32'h1);
    apb(1'h1, 8'h44, 32'h64);
    frz(0, 1, 0, 2);
    // Code 7 keeps levels frozen with no timeout
    apb(1'h1, 8'h44, 32'h7C);
    repeat (3000) @(posedge pclk);
    @(negedge pclk);
    `CHK(freeze_levels, 1'h1)
    apb(1'h1, 8'h44, 32'h60);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    `CHK(freeze_levels, 1'h0)
    results();
  end
endmodule

`default_nettype wire
